// ===== verilog/lcdpg_top.sv
// LCD shared port group: four ports, direction and data latches, pin group enable
`timescale 1ns/1ps

module lcdpg_top
    import lcdpg_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_en,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [LCDPG_AW-1:0] paddr,
    input  wire logic [LCDPG_DW-1:0] pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [LCDPG_DW-1:0] prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Pins
    input  wire lcdpg_pins_s         pin_in,
    output logic      [4:0]          pin_d_out,
    output logic      [4:0]          pin_d_oe,
    // LCD waveforms and pin steering
    input  wire logic [31:0]         seg_wave,
    input  wire logic [2:0]          com_wave,
    input  wire logic                com_mode,
    output lcdpg_pins_s              lcd_en,
    output lcdpg_pins_s              lcd_level
);

    // Byte addresses
    localparam logic [LCDPG_AW-1:0] ADDR_PD = {IDX_PORT_D_DATA, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_PE = {IDX_PORT_E_DATA, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_PF = {IDX_PORT_F_DATA, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_PG = {IDX_PORT_G_DATA, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_TD = {IDX_PORT_D_DIR, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_TE = {IDX_PORT_E_DIR, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_TF = {IDX_PORT_F_DIR, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_TG = {IDX_PORT_G_DIR, 2'b00};
    localparam logic [LCDPG_AW-1:0] ADDR_SE = {IDX_GRP_ENABLE, 2'b00};

    // Register storage
    logic [7:0] data_latch [4];
    logic [7:0] dir_reg    [4];
    logic [7:0] grp;

    // Address decode
    logic        hit_data;
    logic        hit_dir;
    logic        hit_grp;
    logic        hit;
    lcdpg_port_e sel_port;

    assign hit_data = (paddr == ADDR_PD) || (paddr == ADDR_PE)
                   || (paddr == ADDR_PF) || (paddr == ADDR_PG);
    assign hit_dir  = (paddr == ADDR_TD) || (paddr == ADDR_TE)
                   || (paddr == ADDR_TF) || (paddr == ADDR_TG);
    assign hit_grp  = (paddr == ADDR_SE);
    assign hit      = hit_data || hit_dir || hit_grp;

    assign sel_port = ((paddr == ADDR_PD) || (paddr == ADDR_TD)) ? PORT_D :
                      ((paddr == ADDR_PE) || (paddr == ADDR_TE)) ? PORT_E :
                      ((paddr == ADDR_PF) || (paddr == ADDR_TF)) ? PORT_F :
                                                                   PORT_G;

    // Bus phases
    logic setup_ph;
    logic wr_take;

    assign setup_ph = psel && !penable;
    assign wr_take  = psel && penable && pready && pwrite && pstrb[0] && hit;

    // Read data: data registers return the pin levels, not the latch
    logic [7:0] pin_port [4];
    logic [7:0] rd_byte;

    assign pin_port[PORT_D] = pin_in.d;
    assign pin_port[PORT_E] = pin_in.e;
    assign pin_port[PORT_F] = pin_in.f;
    assign pin_port[PORT_G] = pin_in.g;

    assign rd_byte = hit_data ? pin_port[sel_port] :
                     hit_dir  ? dir_reg[sel_port]  :
                     hit_grp  ? grp                :
                                8'h00;

    // APB answer: one access cycle, data captured in setup
    logic                next_pready;
    logic [LCDPG_DW-1:0] next_prdata;
    logic                next_pslverr;

    assign next_pready  = setup_ph;
    assign next_prdata  = (setup_ph && !pwrite) ? {24'h000000, rd_byte} : prdata;
    assign next_pslverr = setup_ph && !hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Register writes; a write stores the whole byte into the latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_latch[i] <= DATA_RST;
                dir_reg[i]    <= DIR_RST;
            end
            grp <= GRP_RST;
        end
        else if (clk_en && wr_take)
        begin
            if (hit_data)
                data_latch[sel_port] <= pwdata[7:0];
            else if (hit_dir)
                dir_reg[sel_port] <= pwdata[7:0];
            else
                grp <= pwdata[7:0];
        end
    end

    // Per-pin LCD ownership and waveform
    logic [31:0] next_lcd_en;
    logic [31:0] next_lcd_level;

    genvar p;
    generate
        for (p = 0; p < 32; p++)
        begin : g_pin
            localparam int unsigned SEG = lcdpg_seg_of_pin(p);
            localparam int unsigned GB  = lcdpg_grp_of_seg(SEG);
            // Group bit owns this pin's segment
            assign next_lcd_en[p] = grp[GB];
            if (p >= 5 && p <= 7)
            begin : g_com
                // Port D high pins carry commons in multiplex mode
                assign next_lcd_level[p] = com_mode ? com_wave[7-p]
                                                    : seg_wave[SEG];
            end
            else
            begin : g_seg
                assign next_lcd_level[p] = seg_wave[SEG];
            end
        end
    endgenerate

    // Port D low pins: driver only when digital and direction says output
    logic [4:0] next_d_oe;
    logic [4:0] next_d_out;

    assign next_d_oe  = grp[GRP_SEG0_BIT] ? 5'h00
                                          : ~dir_reg[PORT_D][BIDIR_PINS-1:0];
    assign next_d_out = data_latch[PORT_D][BIDIR_PINS-1:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_d_oe  <= 5'h00;
            pin_d_out <= 5'h00;
            lcd_en    <= '1;
            lcd_level <= '0;
        end
        else if (clk_en)
        begin
            pin_d_oe  <= next_d_oe;
            pin_d_out <= next_d_out;
            lcd_en    <= next_lcd_en;
            lcd_level <= next_lcd_level;
        end
    end

    // Checks

    AST_D_OE_GATED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pin_d_oe != 5'h00) |-> !$past(grp[GRP_SEG0_BIT]))
        else $error("port D driver on while its group is LCD");

    AST_D_OE_DIR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !grp[GRP_SEG0_BIT]) |=> (pin_d_oe == ~$past(dir_reg[PORT_D][4:0])))
        else $error("port D enable does not follow direction");

    AST_D_LCD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && grp[GRP_SEG0_BIT]) |=> (lcd_en.d[4:0] == 5'h1f) && (pin_d_oe == 5'h00))
        else $error("port D low pins not on LCD");

    AST_GRP_RESET: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> (grp == GRP_RST) && (lcd_en == '1))
        else $error("group enable not all ones after reset");

    AST_PORT_RESET: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> (data_latch[PORT_E] == DATA_RST) && (dir_reg[PORT_G] == DIR_RST))
        else $error("port registers wrong after reset");

    AST_PORT_F: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !grp[GRP_SEG12_BIT] && !grp[GRP_SEG16_BIT]) |=> (lcd_en.f == 8'h00))
        else $error("port F not released");

    AST_PORT_E: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !grp[GRP_SEG27_BIT] && !grp[GRP_SEG5_BIT] && !grp[GRP_SEG9_BIT])
        |=> (lcd_en.e == 8'h00) && !lcd_en.g[7])
        else $error("port E or G7 not released");

    AST_PORT_G: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !grp[GRP_SEG27_BIT] && !grp[GRP_SEG20_BIT])
        |=> (lcd_en.g == 8'h00) && !lcd_en.e[7])
        else $error("port G or E7 not released");

    AST_D_COM: assert property (
        @(posedge pclk) disable iff (!presetn)
        (presetn && clk_en && grp[GRP_SEG29_BIT] && com_mode)
        |=> (lcd_en.d[7:5] == 3'b111) && (lcd_level.d[7] == $past(com_wave[0])))
        else $error("port D high pins not carrying commons");

    AST_RD_PINS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && setup_ph && !pwrite && (paddr == ADDR_PF))
        |=> pready && (prdata[7:0] == $past(pin_in.f)))
        else $error("port read does not return pin levels");

    AST_WR_LATCH: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_take && (paddr == ADDR_PG))
        |=> (data_latch[PORT_G] == $past(pwdata[7:0])))
        else $error("port write not stored in latch");

endmodule // lcdpg_top

// ===== verilog/lcdpg_pkg.sv
// Package for the LCD shared port group: register map, resets and pin carrier
package lcdpg_pkg;

    // Bus address width and data width
    localparam int unsigned LCDPG_AW = 11;
    localparam int unsigned LCDPG_DW = 32;

    // Register indices; the byte address is four times the index
    localparam logic [8:0] IDX_PORT_D_DATA = 9'h008;
    localparam logic [8:0] IDX_PORT_E_DATA = 9'h009;
    localparam logic [8:0] IDX_PORT_D_DIR  = 9'h088;
    localparam logic [8:0] IDX_PORT_E_DIR  = 9'h089;
    localparam logic [8:0] IDX_PORT_F_DATA = 9'h107;
    localparam logic [8:0] IDX_PORT_G_DATA = 9'h108;
    localparam logic [8:0] IDX_GRP_ENABLE  = 9'h10d;
    localparam logic [8:0] IDX_PORT_F_DIR  = 9'h187;
    localparam logic [8:0] IDX_PORT_G_DIR  = 9'h188;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [7:0] GRP_RST  = 8'hff;

    // Group enable bit positions, named by first segment of the group
    localparam int unsigned GRP_SEG0_BIT  = 0;
    localparam int unsigned GRP_SEG5_BIT  = 1;
    localparam int unsigned GRP_SEG9_BIT  = 2;
    localparam int unsigned GRP_SEG12_BIT = 3;
    localparam int unsigned GRP_SEG16_BIT = 4;
    localparam int unsigned GRP_SEG20_BIT = 5;
    localparam int unsigned GRP_SEG27_BIT = 6;
    localparam int unsigned GRP_SEG29_BIT = 7;

    // Number of bidirectional pins on the first port
    localparam int unsigned BIDIR_PINS = 5;

    // Port selector
    typedef enum logic [1:0] {
        PORT_D = 2'b00,
        PORT_E = 2'b01,
        PORT_F = 2'b10,
        PORT_G = 2'b11
    } lcdpg_port_e;

    // One bit per pin of the four ports
    typedef struct packed {
        logic [7:0] g;
        logic [7:0] f;
        logic [7:0] e;
        logic [7:0] d;
    } lcdpg_pins_s;

    // Segment number carried by a flat pin index (port * 8 + bit)
    function automatic int unsigned lcdpg_seg_of_pin(input int unsigned p);
        int unsigned s;
        s = 0;
        if (p < 5)       s = p;
        else if (p < 8)  s = p + 24;
        else if (p < 15) s = p - 3;
        else if (p < 16) s = 27;
        else if (p < 24) s = p - 4;
        else if (p < 31) s = p - 4;
        else             s = 28;
        return s;
    endfunction

    // Group bit that owns a segment
    function automatic int unsigned lcdpg_grp_of_seg(input int unsigned s);
        int unsigned g;
        g = GRP_SEG29_BIT;
        if (s < 5)       g = GRP_SEG0_BIT;
        else if (s < 9)  g = GRP_SEG5_BIT;
        else if (s < 12) g = GRP_SEG9_BIT;
        else if (s < 16) g = GRP_SEG12_BIT;
        else if (s < 20) g = GRP_SEG16_BIT;
        else if (s < 27) g = GRP_SEG20_BIT;
        else if (s < 29) g = GRP_SEG27_BIT;
        return g;
    endfunction

endpackage

// ===== verif/lcdpg_partner.sv
// Far-side model: pin levels seen by the port group
`timescale 1ns/1ps
module lcdpg_partner
    import lcdpg_pkg::*;
(
    // From the port group
    input  wire logic [4:0]  pin_d_out,
    input  wire logic [4:0]  pin_d_oe,
    input  wire lcdpg_pins_s lcd_en,
    input  wire lcdpg_pins_s lcd_level,
    // Outside digital sources
    input  wire logic [31:0] ext_level,
    // Pin levels back
    output lcdpg_pins_s      pin_in
);
    // LCD drive wins, then an enabled output buffer, else the outside source
    wire logic [31:0] drv = {27'h0, pin_d_oe};
    assign pin_in = (lcd_en & lcd_level)
                  | (~lcd_en & drv & {27'h0, pin_d_out})
                  | (~lcd_en & ~drv & ext_level);
endmodule // lcdpg_partner

// ===== verif/tb_lcd_shared_port_group.sv
// Testbench for the LCD shared port group
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_lcd_shared_port_group
    import lcdpg_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [10:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] seg_wave = '0;
    logic [31:0] ext_level = '0;
    logic [2:0]  com_wave = '0;
    logic        com_mode = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  pin_d_out;
    logic [4:0]  pin_d_oe;
    lcdpg_pins_s pin_in;
    lcdpg_pins_s lcd_en;
    lcdpg_pins_s lcd_level;
    logic [31:0] rd;
    logic        err;
    int          n_errors = 0;
    int          n_tests = 0;

    always #50 pclk = ~pclk;

    lcdpg_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe),
        .seg_wave(seg_wave), .com_wave(com_wave), .com_mode(com_mode),
        .lcd_en(lcd_en), .lcd_level(lcd_level));

    lcdpg_partner far_side (.pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe), .lcd_en(lcd_en),
        .lcd_level(lcd_level), .ext_level(ext_level), .pin_in(pin_in));

    function automatic int seg_of(input int p);
        return p < 5 ? p : p < 8 ? p + 24 : p < 15 ? p - 3 : p == 15 ? 27 : p < 31 ? p - 4 : 28;
    endfunction

    function automatic int grp_of(input int s);
        return s < 5 ? 0 : s < 9 ? 1 : s < 12 ? 2 : s < 16 ? 3 : s < 20 ? 4 : s < 27 ? 5
             : s < 29 ? 6 : 7;
    endfunction

    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // One APB transfer; result lands in rd and err
    task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset_values;
        logic [8:0] dirs [4] = '{IDX_PORT_D_DIR, IDX_PORT_E_DIR, IDX_PORT_F_DIR, IDX_PORT_G_DIR};
        `CHK(lcd_en, 32'hffffffff)
        `CHK(pin_d_oe, 5'h00)
        apb(0, IDX_GRP_ENABLE, 0);
        `CHK(rd, 32'h000000ff)
        `CHK(err, 1'b0)
        foreach (dirs[i])
        begin
            apb(0, dirs[i], 0);
            `CHK(rd, 32'h000000ff)
        end
    endtask

    task automatic t_groups;
        logic [31:0] exp_v;
        seg_wave <= 32'h9c3a5e71;
        com_wave <= 3'h5;
        for (int m = 0; m < 2; m++)
        begin
            com_mode <= m[0];
            repeat (3) @(posedge pclk);
            for (int p = 0; p < 32; p++)
                exp_v[p] = (m == 1 && p >= 5 && p < 8) ? com_wave[7 - p] : seg_wave[seg_of(p)];
            `CHK(lcd_level, exp_v)
        end
        for (int b = 0; b < 8; b++)
        begin
            apb(1, IDX_GRP_ENABLE, ~(8'h01 << b));
            repeat (2) @(posedge pclk);
            for (int p = 0; p < 32; p++)
                exp_v[p] = (grp_of(seg_of(p)) != b);
            `CHK(lcd_en, exp_v)
        end
    endtask

    task automatic t_direction;
        apb(1, IDX_GRP_ENABLE, 8'hfe);
        apb(1, IDX_PORT_D_DIR, 8'he7);
        repeat (2) @(posedge pclk);
        `CHK(pin_d_oe, 5'h18)
        `CHK(pin_d_out, 5'h00)
        apb(1, IDX_PORT_D_DATA, 8'h15);
        repeat (2) @(posedge pclk);
        `CHK(pin_d_out, 5'h15)
        apb(1, IDX_GRP_ENABLE, 8'hff);
        repeat (2) @(posedge pclk);
        `CHK(pin_d_oe, 5'h00)
        apb(1, IDX_PORT_E_DIR, 8'h5a);
        apb(0, IDX_PORT_E_DIR, 0);
        `CHK(rd, 32'h0000005a)
    endtask

    task automatic t_rmw;
        ext_level <= 32'hc3965a0a;
        apb(1, IDX_GRP_ENABLE, 8'h00);
        apb(1, IDX_PORT_D_DIR, 8'hff);
        apb(1, IDX_PORT_G_DATA, 8'h3c);
        apb(0, IDX_PORT_G_DATA, 0);
        `CHK(rd, 32'h000000c3)
        apb(0, IDX_PORT_F_DATA, 0);
        `CHK(rd, 32'h00000096)
        apb(0, IDX_PORT_E_DATA, 0);
        `CHK(rd, 32'h0000005a)
        // Bit-set done as software does it: read pins, set, write latch
        apb(0, IDX_PORT_D_DATA, 0);
        `CHK(rd, 32'h0000000a)
        apb(1, IDX_PORT_D_DATA, rd[7:0] | 8'h01);
        apb(1, IDX_PORT_D_DIR, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK(pin_d_out, 5'h0b)
        `CHK(pin_d_oe, 5'h1f)
    endtask

    task automatic t_unmapped;
        apb(1, 9'h001, 8'h55);
        `CHK(err, 1'b1)
        apb(0, 9'h001, 0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
    endtask

    initial
    begin
        #2000000;
        $display("Error %0t: timeout", $time);
        n_errors++;
        end_sim();
    end

    initial
    begin
        do_reset();
        t_reset_values();
        t_groups();
        t_direction();
        t_rmw();
        t_unmapped();
        do_reset();
        t_reset_values();
        apb(1, IDX_GRP_ENABLE, 8'hfe);
        apb(1, IDX_PORT_D_DIR, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK(pin_d_out, 5'h00)
        end_sim();
    end
endmodule // tb_lcd_shared_port_group
